// File: logic/cacr_regs.sv
// converter adc and thermal charge configuration register pair
`timescale 1ns/10ps
// Overview of operation
// - host start bit launches one-shot conversion
// - start bit clears after a one-shot conversion finishes
// - start bit reads one while converting
// - converter enable sets start bit
// - continuous mode ignores host start writes
// - bit 7 selects one-shot or continuous
// - bits 6:4 select switching rate
// - bit 15 enables die heat limit
// - bits 14:12 select regulation point
// - trickle current 50 mA steps
// - precharge current 100 mA steps
// - termination current 50 mA steps
// - otp may supply the defaults restored on watchdog expiry; reset loads the fixed ones
module cacr_regs
   import cacr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic conv_enabled,
   input wire logic adc_done,
   input wire logic wdt_expire,
   input wire logic otp_load,
   input wire logic [2:0] otp_rate,
   input wire logic [15:0] otp_therm,
   output logic [15:0] rd_data,
   output logic adc_run,
   output logic adc_continuous,
   output logic [10:0] rate_khz,
   output logic heat_en,
   output logic [6:0] heat_degc,
   output logic [10:0] trickle_ma,
   output logic [10:0] precharge_ma,
   output logic [10:0] term_ma
);
   logic start_q, start_d;
   logic repeat_q, repeat_d;
   logic [2:0] rate_q, rate_d;
   logic [15:0] therm_q, therm_d;
   logic [2:0] rate_dflt_q, rate_dflt_d;
   logic [15:0] therm_dflt_q, therm_dflt_d;
   logic conv_en_q, conv_en_d;
   cacr_conv_t state_q, state_d;
   logic [15:0] rd_data_q, rd_data_d;
   logic [15:0] conv_view;
   logic [10:0] rate_khz_c, trickle_c, prechg_c, term_c;
   logic [6:0] heat_degc_c;
   logic heat_en_c;
   logic [10:0] rate_khz_q, trickle_q, prechg_q, term_q;
   logic [6:0] heat_degc_q;
   logic heat_en_q;
   logic wr_conv, wr_therm;

   assign wr_conv = wr_en && (addr == CACR_ADDR_CONV);
   assign wr_therm = wr_en && (addr == CACR_ADDR_THERM);

   assign conv_view = {7'h00, start_q, repeat_q, rate_q, 4'h0};

   always_comb
   begin
      rate_dflt_d = rate_dflt_q;
      therm_dflt_d = therm_dflt_q;
      if (otp_load)
      begin
         rate_dflt_d = otp_rate;
         therm_dflt_d = otp_therm;
      end
   end

   always_comb
   begin
      start_d = start_q;
      repeat_d = repeat_q;
      rate_d = rate_q;
      therm_d = therm_q;
      state_d = state_q;
      conv_en_d = conv_enabled;
      unique case (state_q)
         CACR_IDLE:
         begin
            if (start_q)
               state_d = CACR_BUSY;
         end
         CACR_BUSY:
         begin
            start_d = 1'b1;
            if (adc_done && !repeat_q)
            begin
               start_d = 1'b0;
               state_d = CACR_IDLE;
            end
         end
         default:
            state_d = CACR_IDLE;
      endcase
      // host writes come after the state step, so a start on the done cycle is kept
      if (wr_conv)
      begin
         repeat_d = wr_data[CACR_REPEAT_BIT];
         rate_d = wr_data[CACR_RATE_LSB +: 3];
         if (!repeat_q && wr_data[CACR_START_BIT])
            start_d = 1'b1;
      end
      if (wr_therm)
         therm_d = wr_data;
      if (wdt_expire)
      begin
         rate_d = rate_dflt_q;
         therm_d = therm_dflt_q;
      end
      if (conv_enabled && !conv_en_q)
         start_d = 1'b1;
   end

   always_comb
   begin
      rd_data_d = rd_data_q;
      if (rd_en)
      begin
         unique case (addr)
            CACR_ADDR_CONV: rd_data_d = conv_view;
            CACR_ADDR_THERM: rd_data_d = therm_q;
            default: rd_data_d = 16'h0000;
         endcase
      end
   end

   cacr_decode u_decode (
      .conv_reg(conv_view),
      .therm_reg(therm_q),
      .rate_khz(rate_khz_c),
      .heat_en(heat_en_c),
      .heat_degc(heat_degc_c),
      .trickle_ma(trickle_c),
      .precharge_ma(prechg_c),
      .term_ma(term_c)
   );

   // otp defaults survive the watchdog; only a reset brings back the fixed ones
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rate_dflt_q <= CACR_RATE_RST;
         therm_dflt_q <= CACR_THERM_RST;
      end
      else
      begin
         rate_dflt_q <= rate_dflt_d;
         therm_dflt_q <= therm_dflt_d;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         start_q <= 1'b0;
         repeat_q <= 1'b0;
         rate_q <= CACR_RATE_RST;
         therm_q <= CACR_THERM_RST;
         state_q <= CACR_IDLE;
         conv_en_q <= 1'b0;
      end
      else
      begin
         start_q <= start_d;
         repeat_q <= repeat_d;
         rate_q <= rate_d;
         therm_q <= therm_d;
         state_q <= state_d;
         conv_en_q <= conv_en_d;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rd_data_q <= 16'h0000;
      end
      else
      begin
         rd_data_q <= rd_data_d;
      end
   end

   // decoded settings lag the register by one cycle, traded for flopped outputs
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rate_khz_q <= CACR_RATE_KHZ[CACR_RATE_RST];
         heat_en_q <= CACR_THERM_RST[CACR_HEAT_EN_BIT];
         heat_degc_q <= CACR_HEAT_DEGC[CACR_THERM_RST[CACR_HEAT_PT_LSB +: 3]];
         trickle_q <= 11'(CACR_THERM_RST[CACR_TRICKLE_LSB +: 4]) * CACR_TRICKLE_STEP_MA;
         prechg_q <= 11'(CACR_THERM_RST[CACR_PRECHG_LSB +: 4]) * CACR_PRECHG_STEP_MA;
         term_q <= 11'(CACR_THERM_RST[CACR_TERM_LSB +: 4]) * CACR_TERM_STEP_MA;
      end
      else
      begin
         rate_khz_q <= rate_khz_c;
         heat_en_q <= heat_en_c;
         heat_degc_q <= heat_degc_c;
         trickle_q <= trickle_c;
         prechg_q <= prechg_c;
         term_q <= term_c;
      end
   end

   assign rd_data = rd_data_q;
   assign adc_run = start_q;
   assign adc_continuous = repeat_q;
   assign rate_khz = rate_khz_q;
   assign heat_en = heat_en_q;
   assign heat_degc = heat_degc_q;
   assign trickle_ma = trickle_q;
   assign precharge_ma = prechg_q;
   assign term_ma = term_q;

   sequence busy_s;
      state_q == CACR_BUSY;
   endsequence

   sequence done_s;
      adc_done && !repeat_q;
   endsequence

   sequence quiet_s;
      !wr_conv && !(conv_enabled && !conv_en_q);
   endsequence

   start_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_conv && wr_data[CACR_START_BIT] && !repeat_q) |=> adc_run)
      else $error("one-shot start write did not start conversion");

   start_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      (busy_s ##0 done_s ##0 quiet_s) |=> !adc_run)
      else $error("start bit not cleared after conversion");

   busy_high_a: assert property (@(posedge ref_clk) disable iff (rst)
      (busy_s ##0 (rd_en && addr == CACR_ADDR_CONV)) |=> rd_data[CACR_START_BIT])
      else $error("start bit read low while converting");

   conv_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
      (conv_enabled && !conv_en_q) |=> adc_run)
      else $error("converter enable did not set start bit");

   cont_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
      (repeat_q && !adc_run && state_q == CACR_IDLE && !(conv_enabled && !conv_en_q))
      |=> !adc_run)
      else $error("start accepted in continuous mode");

   mode_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      wr_conv |=> adc_continuous == $past(wr_data[CACR_REPEAT_BIT]))
      else $error("mode bit not written");

   wdt_restore_a: assert property (@(posedge ref_clk) disable iff (rst)
      (wdt_expire && !wr_conv) |=> (therm_q == $past(therm_dflt_q)) &&
      (rate_q == $past(rate_dflt_q)) && (repeat_q == $past(repeat_q)))
      else $error("watchdog restore wrong");

   resv_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      (rd_en && addr == CACR_ADDR_CONV) |=> (rd_data & ~CACR_CONV_MASK) == 16'h0000)
      else $error("reserved bits read nonzero");

   rate_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
      (rate_q == 3'h4) |=> rate_khz == 11'h2ee)
      else $error("rate code 100 not 750 khz");

   heat_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
      (wr_therm && !wdt_expire) |-> ##2 heat_en == $past(wr_data[CACR_HEAT_EN_BIT], 2))
      else $error("regulation enable does not follow write");

   heat_point_a: assert property (@(posedge ref_clk) disable iff (rst)
      (therm_q[CACR_HEAT_PT_LSB +: 3] == 3'h0) |=> heat_degc == 7'h50)
      else $error("regulation point code 000 not 80 c");

   trickle_top_a: assert property (@(posedge ref_clk) disable iff (rst)
      (therm_q[CACR_TRICKLE_LSB +: 4] == 4'hf) |=> trickle_ma == 11'h2ee)
      else $error("trickle code 1111 not 750 ma");

   precharge_sum_a: assert property (@(posedge ref_clk) disable iff (rst)
      (therm_q[CACR_PRECHG_LSB +: 4] == 4'h7) |=> precharge_ma == 11'h2bc)
      else $error("precharge code 0111 not 700 ma");

   term_top_a: assert property (@(posedge ref_clk) disable iff (rst)
      (therm_q[CACR_TERM_LSB +: 4] == 4'hf) |=> term_ma == 11'h2ee)
      else $error("termination code 1111 not 750 ma");

   otp_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
      otp_load |=> (therm_dflt_q == $past(otp_therm)) &&
      (rate_dflt_q == $past(otp_rate)))
      else $error("otp defaults not captured");
endmodule

// File: logic/cacr_pkg.sv
// constants for the converter adc and thermal charge configuration registers
package cacr_pkg;
   localparam logic [7:0] CACR_ADDR_CONV = 8'h0e;
   localparam logic [7:0] CACR_ADDR_THERM = 8'h0f;
   // converter_adc_config fields
   localparam int CACR_START_BIT = 8;
   localparam int CACR_REPEAT_BIT = 7;
   localparam int CACR_RATE_LSB = 4;
   // thermal_charge_current_config fields
   localparam int CACR_HEAT_EN_BIT = 15;
   localparam int CACR_HEAT_PT_LSB = 12;
   localparam int CACR_TRICKLE_LSB = 8;
   localparam int CACR_PRECHG_LSB = 4;
   localparam int CACR_TERM_LSB = 0;
   // fixed defaults, loaded by reset and restored by the watchdog until an otp load; conv read mask
   localparam logic [2:0] CACR_RATE_RST = 3'h1;
   localparam logic [15:0] CACR_THERM_RST = 16'hf244;
   localparam logic [15:0] CACR_CONV_MASK = 16'h01f0;
   // switching rate table in khz
   localparam logic [10:0] CACR_RATE_KHZ [8] = '{11'h1f4, 11'h258, 11'h2bc, 11'h320,
      11'h2ee, 11'h384, 11'h3e8, 11'h4b0};
   // die regulation point table in degrees c
   localparam logic [6:0] CACR_HEAT_DEGC [8] = '{7'h50, 7'h5a, 7'h5f, 7'h64,
      7'h69, 7'h6e, 7'h73, 7'h78};
   localparam logic [10:0] CACR_TRICKLE_STEP_MA = 11'h032;
   localparam logic [10:0] CACR_PRECHG_STEP_MA = 11'h064;
   localparam logic [10:0] CACR_TERM_STEP_MA = 11'h032;
   typedef enum logic [1:0] {CACR_IDLE = 2'b00, CACR_BUSY = 2'b01} cacr_conv_t;
endpackage

// File: logic/cacr_decode.sv
// decodes configuration codes into physical settings
`timescale 1ns/10ps
module cacr_decode
   import cacr_pkg::*;
(
   input wire logic [15:0] conv_reg,
   input wire logic [15:0] therm_reg,
   output logic [10:0] rate_khz,
   output logic heat_en,
   output logic [6:0] heat_degc,
   output logic [10:0] trickle_ma,
   output logic [10:0] precharge_ma,
   output logic [10:0] term_ma
);
   always_comb
   begin
      rate_khz = CACR_RATE_KHZ[conv_reg[CACR_RATE_LSB +: 3]];
      heat_en = therm_reg[CACR_HEAT_EN_BIT];
      heat_degc = CACR_HEAT_DEGC[therm_reg[CACR_HEAT_PT_LSB +: 3]];
      trickle_ma = 11'(therm_reg[CACR_TRICKLE_LSB +: 4]) * CACR_TRICKLE_STEP_MA;
      precharge_ma = 11'(therm_reg[CACR_PRECHG_LSB +: 4]) * CACR_PRECHG_STEP_MA;
      term_ma = 11'(therm_reg[CACR_TERM_LSB +: 4]) * CACR_TERM_STEP_MA;
   end
endmodule

// File: test/cacr_adc_model.sv
// converter model that finishes each requested conversion after a fixed span
`timescale 1ns/10ps
module cacr_adc_model #(parameter int DLY = 6)
(
   input wire logic ref_clk,
   input wire logic adc_run,
   output logic adc_done
);
   int cnt_q = 0;
   initial adc_done = 1'b0;
   // done pulse after a fixed span
   always @(posedge ref_clk)
   begin
      cnt_q <= (adc_run && !adc_done) ? cnt_q + 1 : 0;
      adc_done <= adc_run && (cnt_q == DLY);
   end
endmodule

// File: test/charger_adc_thermal_config_regs_test.sv
// self-checking bench for the configuration register pair
`timescale 1ns/10ps
module charger_adc_thermal_config_regs_test;
   import cacr_pkg::*;
   logic ref_clk, rst, wr_en, rd_en, conv_enabled, adc_done, wdt_expire, otp_load;
   logic adc_run, adc_continuous, heat_en;
   logic [7:0] addr;
   logic [15:0] wr_data, otp_therm, rd_data, d;
   logic [2:0] otp_rate;
   logic [10:0] rate_khz, trickle_ma, precharge_ma, term_ma;
   logic [6:0] heat_degc;
   int n_errors = 0;
   int n_checks = 0;
   int khz[8] = '{500, 600, 700, 800, 750, 900, 1000, 1200};
   int degc[8] = '{80, 90, 95, 100, 105, 110, 115, 120};

   cacr_regs DUT (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .conv_enabled(conv_enabled), .adc_done(adc_done),
      .wdt_expire(wdt_expire), .otp_load(otp_load), .otp_rate(otp_rate),
      .otp_therm(otp_therm), .rd_data(rd_data), .adc_run(adc_run),
      .adc_continuous(adc_continuous), .rate_khz(rate_khz), .heat_en(heat_en),
      .heat_degc(heat_degc), .trickle_ma(trickle_ma), .precharge_ma(precharge_ma),
      .term_ma(term_ma));

   cacr_adc_model adc (.ref_clk(ref_clk), .adc_run(adc_run), .adc_done(adc_done));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [15:0] v);
      @(negedge ref_clk);
      addr = a;
      wr_data = v;
      wr_en = 1'b1;
      @(negedge ref_clk);
      wr_en = 1'b0;
   endtask

   // read data settles one cycle after the strobe
   task automatic rd(logic [7:0] a, logic [15:0] e);
      @(negedge ref_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge ref_clk);
      rd_en = 1'b0;
      chk("rd_data", e, rd_data);
   endtask

   task automatic pulse(ref logic s);
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
   endtask

   task automatic stop_test();
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard, far beyond the roughly 130 cycles the sequence needs
   initial
   begin
      #(25 * 3000);
      n_errors++;
      stop_test();
   end

   initial
   begin
      rst = 1'b1;
      {wr_en, rd_en, conv_enabled, wdt_expire, otp_load} = 5'h0;
      {addr, wr_data, otp_rate, otp_therm, d} = '0;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      rd(CACR_ADDR_CONV, 16'h0010);
      rd(CACR_ADDR_THERM, 16'hf244);
      chk("heat_en", 16'h1, 16'(heat_en));
      // reserved low bits always written as zero
      for (int i = 0; i < 8; i++)
      begin
         wr(CACR_ADDR_CONV, 16'(i << 4));
         rd(CACR_ADDR_CONV, 16'(i << 4));
         chk("rate_khz", 16'(khz[i]), 16'(rate_khz));
         d = {1'(i), 3'(i), 4'(i + 8), 4'(7 - i), 4'(15 - i)};
         wr(CACR_ADDR_THERM, d);
         rd(CACR_ADDR_THERM, d);
         chk("heat_en", 16'(i & 1), 16'(heat_en));
         chk("heat_degc", 16'(degc[i]), 16'(heat_degc));
         chk("trickle_ma", 16'((i + 8) * 50), 16'(trickle_ma));
         chk("precharge_ma", 16'((7 - i) * 100), 16'(precharge_ma));
         chk("term_ma", 16'((15 - i) * 50), 16'(term_ma));
      end
      wr(CACR_ADDR_CONV, 16'hfe00);
      rd(CACR_ADDR_CONV, 16'h0000);
      wr(8'h20, 16'hffff);
      rd(8'h20, 16'h0000);
      wr(CACR_ADDR_CONV, 16'h0170);
      chk("adc_run", 16'h1, 16'(adc_run));
      rd(CACR_ADDR_CONV, 16'h0170);
      for (int k = 0; k < 20 && adc_run !== 1'b0; k++)
         @(negedge ref_clk);
      rd(CACR_ADDR_CONV, 16'h0070);
      wr(CACR_ADDR_CONV, 16'h00f0);
      chk("adc_continuous", 16'h1, 16'(adc_continuous));
      wr(CACR_ADDR_CONV, 16'h01f0);
      rd(CACR_ADDR_CONV, 16'h00f0);
      // one rising edge of the converter enable, which then stays on
      @(negedge ref_clk);
      conv_enabled = 1'b1;
      rd(CACR_ADDR_CONV, 16'h01f0);
      wr(CACR_ADDR_THERM, 16'h0000);
      pulse(wdt_expire);
      rd(CACR_ADDR_CONV, 16'h0190);
      rd(CACR_ADDR_THERM, 16'hf244);
      otp_rate = 3'h5;
      otp_therm = 16'h1234;
      pulse(otp_load);
      pulse(wdt_expire);
      rd(CACR_ADDR_CONV, 16'h01d0);
      rd(CACR_ADDR_THERM, 16'h1234);
      // mid-run reset brings back the fixed defaults, not the otp ones
      conv_enabled = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      rd(CACR_ADDR_CONV, 16'h0010);
      rd(CACR_ADDR_THERM, 16'hf244);
      chk("adc_run", 16'h0, 16'(adc_run));
      chk("rate_khz", 16'h0258, 16'(rate_khz));
      chk("heat_degc", 16'h0078, 16'(heat_degc));
      chk("trickle_ma", 16'h0064, 16'(trickle_ma));
      chk("precharge_ma", 16'h0190, 16'(precharge_ma));
      chk("term_ma", 16'h00c8, 16'(term_ma));
      stop_test();
   end
endmodule
